//--- rtl/sfvc_pkg.sv
// Purpose: Shared constants and types for the volatile interface config block
// Assumes: One core clock; serial link pins sampled into that clock
// Notes:   Bit positions follow the 8-bit register layout
package sfvc_pkg;

    // ==========================================
    // Command codes
    localparam logic [7:0] CMD_READ_CFG2   = 8'h15;
    localparam logic [7:0] CMD_READ_ANY    = 8'h65;
    localparam logic [7:0] CMD_WREN_VOL    = 8'h50;
    localparam logic [7:0] CMD_WREN        = 8'h06;
    localparam logic [7:0] CMD_WRITE_REGS  = 8'h01;
    localparam logic [7:0] CMD_WRITE_ANY   = 8'h71;
    localparam logic [7:0] CMD_ENTER_LONG  = 8'hB7;
    localparam logic [7:0] CMD_EXIT_LONG   = 8'hE9;
    localparam logic [7:0] CMD_ENTER_FOUR  = 8'h38;
    localparam logic [7:0] CMD_EXIT_FOUR   = 8'hF5;

    // ==========================================
    // Register layout
    localparam int         BIT_PIN_RESET   = 7;
    localparam int         BIT_DRIVE_HI    = 6;
    localparam int         BIT_DRIVE_LO    = 5;
    localparam int         BIT_RESERVED    = 4;
    localparam int         BIT_FOUR_WIDE   = 3;
    localparam int         BIT_PROT_SCHEME = 2;
    localparam int         BIT_POWERUP_LEN = 1;
    localparam int         BIT_CUR_LEN     = 0;
    localparam logic [7:0] WRITE_MASK      = 8'hED;
    localparam logic [31:0] CFG2_ADDR      = 32'h0080_0003;

    // ==========================================
    // Transfer counts
    localparam logic [5:0] BITS_PER_BYTE   = 6'h08;
    localparam logic [5:0] ADDR_BITS_SHORT = 6'h18;
    localparam logic [5:0] ADDR_BITS_LONG  = 6'h20;
    localparam logic [5:0] READ_ANY_DUMMY  = 6'h08;
    localparam logic [1:0] WRITE_REGS_IDX  = 2'h2;

    // ==========================================
    // Types
    typedef enum logic [6:0] {
        SFVC_IDLE   = 7'h01,
        SFVC_CMD    = 7'h02,
        SFVC_ADDR   = 7'h04,
        SFVC_DUMMY  = 7'h08,
        SFVC_RDATA  = 7'h10,
        SFVC_WDATA  = 7'h20,
        SFVC_IGNORE = 7'h40
    } sfvc_phase_t;

    typedef struct packed {
        logic       sclk;
        logic       cs_n;
        logic [3:0] io;
    } sfvc_pins_t;

    typedef struct packed {
        logic [1:0] drive_strength_select;
        logic       shared_pin_reset_enable;
        logic       protection_scheme_select;
        logic       current_address_length;
        logic       four_wide_mode;
        logic       quad_active;
    } sfvc_cfg_t;

endpackage

//--- rtl/sfvc_top.sv
// Operation
// - Commands 15h and 65h return this register to the host.
// - Commands 01h and 71h write it; 50h enables volatile writes.
// - Bit 7 set: third pin acts as reset when idle, not four wide, or quad enable clear.
// - Bit 7 clear: third pin reset requests are ignored.
// - Bits 6:5 pick drive strength, changeable at any time.
// - Bit 4 is reserved and does nothing.
// - Bit 3 set: all transfers four wide, else serial instructions.
// - Bit 3 set forces quad active regardless of quad enable.
// - Clearing bit 3 leaves the quad enable bit untouched.
// - Command 38h sets bit 3, F5h clears it.
// - Serial, no quad: single/dual reads, pins are protect and reset.
// - Serial with quad: quad reads allowed, second pin is data.
// - Four wide: quad reads, second pin data, third data or reset.
// - Bit 2 picks block range or individual lock protection.
// - Bit 1 read-only, shows address length applying after reset.
// - Bit 0 sets current address length, 1 means four bytes.
// - B7h sets bit 0, E9h clears it.
// - Reprogrammed power-up length also updates bit 0.
// - Any reset reloads volatile fields from the non-volatile copy.
//
// Purpose: Volatile interface config register with its serial command port
// Assumes: Link mode 0, link clock far slower than core_clk
// Notes:   Non-volatile copy and quad enable live outside this block
`timescale 1ns/10ps

module sfvc_top
    import sfvc_pkg::*;
(
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       arst_n,
    // Link pins
    input  wire sfvc_pins_t pin_in,
    output logic [3:0]      io_out,
    output logic [3:0]      io_oe,
    // Non-volatile side
    input  wire logic [7:0] nonvolatile_interface_config,
    input  wire logic       nv_length_update,
    input  wire logic       volatile_first_config_quad,
    // Configuration outputs
    output sfvc_cfg_t       cfg_out,
    output logic            protect_pin_enable
);

    // ==========================================
    // State
    typedef struct packed {
        sfvc_pins_t  p1;
        sfvc_pins_t  p2;
        logic        sclk_d;
        logic        loaded;
        sfvc_phase_t phase;
        logic        width_four;
        logic [7:0]  volatile_interface_config;
        logic [7:0]  cmd;
        logic [31:0] sh;
        logic [5:0]  cnt;
        logic [1:0]  bidx;
        logic        hit;
        logic        wel;
        logic [7:0]  tx;
        logic [3:0]  io_out;
        logic [3:0]  io_oe;
        sfvc_cfg_t   cfg;
        logic        wp_en;
    } sfvc_state_t;

    sfvc_state_t q;
    sfvc_state_t next_q;

    // ==========================================
    // Helpers

    // Read image: bit 1 always mirrors the non-volatile length
    function automatic logic [7:0] read_value(
        input logic [7:0] r,
        input logic [7:0] nv
    );
        read_value = r;
        read_value[BIT_POWERUP_LEN] = nv[BIT_POWERUP_LEN];
    endfunction

    // Host write keeps protected bits
    function automatic logic [7:0] merge_write(
        input logic [7:0] old,
        input logic [7:0] d
    );
        merge_write = (old & ~WRITE_MASK) | (d & WRITE_MASK);
    endfunction

    // Address compare honours the current length
    function automatic logic addr_hit(
        input logic [31:0] a,
        input logic        long_addr
    );
        logic [31:0] m;
        m = long_addr ? a : {8'h00, a[23:0]};
        addr_hit = (m == CFG2_ADDR);
    endfunction

    // ==========================================
    // Next state
    logic       sclk_rise;
    logic       sclk_fall;
    logic       cs_high;
    logic       four;
    logic       pin_reset;
    logic [5:0] step;
    logic [5:0] cnt_n;
    logic [31:0] sh_n;
    logic [7:0] nv;

    always_comb begin
        next_q = q;
        nv = nonvolatile_interface_config;
        // Two-stage synchroniser; only p2 is read
        next_q.p1 = pin_in;
        next_q.p2 = q.p1;
        next_q.sclk_d = q.p2.sclk;
        sclk_rise = q.p2.sclk & ~q.sclk_d;
        sclk_fall = ~q.p2.sclk & q.sclk_d;
        cs_high = q.p2.cs_n;
        // Width fixed per frame, so a mid-frame exit cannot turn io3 data into reset
        four = q.width_four;
        // Third pin as reset when enabled, unless selected in four-wide mode with quad enable set
        pin_reset = q.volatile_interface_config[BIT_PIN_RESET]
                    & ~q.p2.io[3]
                    & (cs_high | ~volatile_first_config_quad | ~four);
        // Nibble per edge in four-wide mode, else one bit on io0
        step = four ? 6'h04 : 6'h01;
        cnt_n = q.cnt + step;
        sh_n = four ? {q.sh[27:0], q.p2.io} : {q.sh[30:0], q.p2.io[0]};

        if (!q.loaded || pin_reset) begin
            // Reload after reset release or third-pin reset
            next_q.volatile_interface_config = {nv[7:2], nv[BIT_POWERUP_LEN],
                                                nv[BIT_POWERUP_LEN]};
            next_q.loaded = 1'b1;
            next_q.phase = SFVC_IDLE;
            next_q.wel = 1'b0;
            next_q.cnt = 6'h00;
            next_q.io_oe = 4'h0;
        end else if (cs_high) begin
            // Write enable is used up by a finished write
            if (q.phase == SFVC_WDATA) begin
                next_q.wel = 1'b0;
            end
            next_q.phase = SFVC_IDLE;
            next_q.cnt = 6'h00;
            next_q.io_oe = 4'h0;
        end else begin
            if (q.phase == SFVC_IDLE) begin
                next_q.phase = SFVC_CMD;
                next_q.cnt = 6'h00;
            end
            if (sclk_rise && q.phase != SFVC_IDLE) begin
                next_q.sh = sh_n;
                next_q.cnt = cnt_n;
                case (q.phase)
                    SFVC_CMD: begin
                        if (cnt_n == BITS_PER_BYTE) begin
                            next_q.cmd = sh_n[7:0];
                            next_q.cnt = 6'h00;
                            next_q.bidx = 2'h0;
                            next_q.phase = SFVC_IGNORE;
                            // Width switches take effect for the next command
                            case (sh_n[7:0])
                                CMD_READ_CFG2: begin
                                    next_q.phase = SFVC_RDATA;
                                    next_q.tx = read_value(q.volatile_interface_config, nv);
                                end
                                CMD_READ_ANY: begin
                                    next_q.phase = SFVC_ADDR;
                                end
                                CMD_WRITE_ANY: begin
                                    next_q.phase = SFVC_ADDR;
                                end
                                CMD_WRITE_REGS: begin
                                    next_q.phase = q.wel ? SFVC_WDATA : SFVC_IGNORE;
                                end
                                CMD_WREN_VOL, CMD_WREN: begin
                                    next_q.wel = 1'b1;
                                end
                                CMD_ENTER_FOUR: begin
                                    next_q.volatile_interface_config[BIT_FOUR_WIDE] = 1'b1;
                                end
                                CMD_EXIT_FOUR: begin
                                    next_q.volatile_interface_config[BIT_FOUR_WIDE] = 1'b0;
                                end
                                CMD_ENTER_LONG: begin
                                    next_q.volatile_interface_config[BIT_CUR_LEN] = 1'b1;
                                end
                                CMD_EXIT_LONG: begin
                                    next_q.volatile_interface_config[BIT_CUR_LEN] = 1'b0;
                                end
                                default: begin
                                    next_q.phase = SFVC_IGNORE;
                                end
                            endcase
                        end
                    end
                    SFVC_ADDR: begin
                        // Address width follows the current length bit
                        if (cnt_n == (q.volatile_interface_config[BIT_CUR_LEN]
                                      ? ADDR_BITS_LONG : ADDR_BITS_SHORT)) begin
                            next_q.cnt = 6'h00;
                            next_q.hit = addr_hit(sh_n, q.volatile_interface_config[BIT_CUR_LEN]);
                            if (q.cmd == CMD_READ_ANY) begin
                                next_q.phase = SFVC_DUMMY;
                            end else begin
                                next_q.phase = q.wel ? SFVC_WDATA : SFVC_IGNORE;
                            end
                        end
                    end
                    SFVC_DUMMY: begin
                        // Dummy counts clocks, not bits
                        next_q.cnt = q.cnt + 6'h01;
                        if (q.cnt + 6'h01 == READ_ANY_DUMMY) begin
                            next_q.phase = SFVC_RDATA;
                            next_q.tx = q.hit ? read_value(q.volatile_interface_config, nv)
                                              : 8'h00;
                        end
                    end
                    SFVC_WDATA: begin
                        if (cnt_n == BITS_PER_BYTE) begin
                            next_q.cnt = 6'h00;
                            // Register write: third byte; any-register: address hit
                            if ((q.cmd == CMD_WRITE_REGS) ? (q.bidx == WRITE_REGS_IDX)
                                                          : q.hit) begin
                                next_q.volatile_interface_config =
                                    merge_write(q.volatile_interface_config, sh_n[7:0]);
                            end
                            if (q.bidx != 2'h3) begin
                                next_q.bidx = q.bidx + 2'h1;
                            end
                        end
                    end
                    default: begin
                        next_q.cnt = q.cnt;
                    end
                endcase
            end
            // Data leaves on the falling edge; rotation repeats the byte
            if (sclk_fall && q.phase == SFVC_RDATA) begin
                if (four) begin
                    next_q.io_out = q.tx[7:4];
                    next_q.io_oe = 4'hF;
                    next_q.tx = {q.tx[3:0], q.tx[7:4]};
                end else begin
                    next_q.io_out = {2'b00, q.tx[7], 1'b0};
                    next_q.io_oe = 4'h2;
                    next_q.tx = {q.tx[6:0], q.tx[7]};
                end
            end
        end

        // Non-volatile length reprogrammed: follow it now
        if (nv_length_update) begin
            next_q.volatile_interface_config[BIT_CUR_LEN] = nv[BIT_POWERUP_LEN];
        end

        // Frame width follows the register only between frames
        if (next_q.phase == SFVC_IDLE) begin
            next_q.width_four = next_q.volatile_interface_config[BIT_FOUR_WIDE];
        end

        // Registered configuration outputs
        next_q.cfg.drive_strength_select =
            next_q.volatile_interface_config[BIT_DRIVE_HI:BIT_DRIVE_LO];
        next_q.cfg.shared_pin_reset_enable =
            next_q.volatile_interface_config[BIT_PIN_RESET];
        next_q.cfg.protection_scheme_select =
            next_q.volatile_interface_config[BIT_PROT_SCHEME];
        next_q.cfg.current_address_length =
            next_q.volatile_interface_config[BIT_CUR_LEN];
        next_q.cfg.four_wide_mode =
            next_q.volatile_interface_config[BIT_FOUR_WIDE];
        // Quad forced on in four-wide mode; quad enable itself is never written
        next_q.cfg.quad_active = next_q.volatile_interface_config[BIT_FOUR_WIDE]
                                 | volatile_first_config_quad;
        // Second pin is write protect only without quad
        next_q.wp_en = ~next_q.cfg.quad_active;
    end

    // ==========================================
    // Registers
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
            q.p1 <= 6'h1F; // Idle pins: clock low, deselected, data high
            q.p2 <= 6'h1F;
            q.sclk_d <= 1'b0; // Matches idle clock, no false edge
            q.phase <= SFVC_IDLE;
            q.wp_en <= 1'b1;
        end else begin
            q <= next_q;
        end
    end

    // ==========================================
    // Outputs straight from flops
    assign io_out = q.io_out;
    assign io_oe = q.io_oe;
    assign cfg_out = q.cfg;
    assign protect_pin_enable = q.wp_en;

endmodule

//--- testbench/sfvc_host.sv
// Purpose: Host link controller model, mode 0, MSB first
// Assumes: 160 ns link clock built from core_clk falling edges
// Notes:   Link clock stands low between frames
`timescale 1ns/10ps

module sfvc_host
    import sfvc_pkg::*;
(
    // Time base
    input wire logic       core_clk,
    // Resolved data lines
    input wire logic [3:0] pin_io,
    // Link outputs
    output logic           sclk,
    output logic           cs_n,
    output logic [3:0]     io
);
    // ==========================================
    // Idle levels: reset and protect pins inactive high
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        io = 4'hF;
    end

    // ==========================================
    // One whole frame: tx left-justified, nt/nr in bits, nd clocks
    task automatic frame(input logic four, input logic [47:0] tx, input int nt, nd, nr,
                         output logic [7:0] rd);
        int w;
        int c;
        logic [47:0] s;
        w = four ? 4 : 1;
        s = tx;
        rd = 8'h00;
        cs_n = 1'b0;
        for (c = 0; c < nt / w + nd + nr / w; c++) begin
            if (c < nt / w) io = four ? s[47:44] : {3'h7, s[47]};
            else if (four) io = ~io; // Released lines toggle, no stale value
            else io[0] = ~io[0];
            s = s << w;
            repeat (4) @(negedge core_clk);
            sclk = 1'b1;
            repeat (4) @(negedge core_clk);
            // Sample late: answer comes some core cycles after the fall
            if (c >= nt / w + nd) rd = four ? {rd[3:0], pin_io} : {rd[6:0], pin_io[1]};
            sclk = 1'b0;
        end
        io = 4'hF; // Reset pin high before deselect
        repeat (4) @(negedge core_clk);
        cs_n = 1'b1;
        repeat (8) @(negedge core_clk);
    endtask

    // ==========================================
    // Pull the shared third pin low while deselected
    task automatic pin_reset(input int n);
        io[3] = 1'b0;
        repeat (n) @(negedge core_clk);
        io[3] = 1'b1;
        repeat (6) @(negedge core_clk);
    endtask
endmodule

//--- testbench/sfvc_top_monitor.sv
// Purpose: Port checks for the volatile interface config block
// Assumes: One core_clk domain, async active-low reset
// Notes:   Bound to every sfvc_top
`timescale 1ns/10ps

module sfvc_top_monitor
    import sfvc_pkg::*;
(
    // Clock and reset
    input wire logic       core_clk,
    input wire logic       arst_n,
    // Watched ports
    input wire sfvc_pins_t pin_in,
    input wire logic [3:0] io_oe,
    input wire logic [7:0] nonvolatile_interface_config,
    input wire logic       nv_length_update,
    input wire logic       volatile_first_config_quad,
    input wire sfvc_cfg_t  cfg_out,
    input wire logic       protect_pin_enable
);
    // ==========================================
    // Clocking, reset masks all checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    // ==========================================
    // Mode and pin role checks
    chk_quad_forced: assert property (
        $past(arst_n) |-> cfg_out.quad_active == (cfg_out.four_wide_mode | $past(volatile_first_config_quad)))
        else $error("quad active mismatch");
    chk_protect_pin: assert property (
        protect_pin_enable == !cfg_out.quad_active) else $error("protect pin role wrong");
    chk_oe_width: assert property (
        io_oe != 4'h0 |-> io_oe == (cfg_out.four_wide_mode ? 4'hF : 4'h2))
        else $error("output enable width wrong");
    chk_oe_release: assert property (
        pin_in.cs_n [*6] |-> io_oe == 4'h0) else $error("output driven while deselected");

    // ==========================================
    // Register load checks
    chk_length_follow: assert property (
        nv_length_update |-> ##2 cfg_out.current_address_length == nonvolatile_interface_config[1])
        else $error("address length did not follow update");
    chk_idle_hold: assert property (
        (pin_in.cs_n && !cfg_out.shared_pin_reset_enable) [*6] |=> $stable({cfg_out.drive_strength_select,
        cfg_out.protection_scheme_select, cfg_out.four_wide_mode, cfg_out.shared_pin_reset_enable}))
        else $error("config changed while idle");
    chk_pin_reset: assert property (
        (cfg_out.shared_pin_reset_enable && pin_in.cs_n && !pin_in.io[3]) [*6]
        |-> cfg_out.protection_scheme_select == nonvolatile_interface_config[2]
        && cfg_out.drive_strength_select == nonvolatile_interface_config[6:5])
        else $error("pin reset did not reload");
    chk_reset_load: assert property (
        $rose(arst_n) |-> ##2 cfg_out.four_wide_mode == nonvolatile_interface_config[3]
        && cfg_out.shared_pin_reset_enable == nonvolatile_interface_config[7])
        else $error("reset load wrong");
endmodule

bind sfvc_top sfvc_top_monitor mon (
    .core_clk(core_clk), .arst_n(arst_n), .pin_in(pin_in), .io_oe(io_oe),
    .nonvolatile_interface_config(nonvolatile_interface_config), .nv_length_update(nv_length_update),
    .volatile_first_config_quad(volatile_first_config_quad), .cfg_out(cfg_out),
    .protect_pin_enable(protect_pin_enable));

//--- testbench/tb_sfvc_top.sv
// Purpose: Self-checking bench for the volatile interface config block
// Assumes: Host model drives the link, bench drives side inputs
// Notes:   Register model is an int kept beside the design
`timescale 1ns/10ps

module tb_sfvc_top
    import sfvc_pkg::*;
;
    // ==========================================
    // Signals
    logic        core_clk  = 1'b0;
    logic        arst_n    = 1'b0;
    logic        len_pulse = 1'b0;
    logic        q         = 1'b1;
    logic [7:0]  nv;
    logic        sclk;
    logic        cs_n;
    logic [3:0]  host_io;
    logic [3:0]  io_out;
    logic [3:0]  io_oe;
    sfvc_pins_t  pins;
    sfvc_cfg_t   cfg_out;
    logic        protect_pin_enable;
    logic [31:0] seed = 32'h0000_0061;
    int          m;
    int          errors   = 0;
    int          n_checks = 0;

    always #10 core_clk = ~core_clk;
    // Wire level: whoever enables wins
    assign pins = '{sclk: sclk, cs_n: cs_n, io: (io_oe & io_out) | (~io_oe & host_io)};

    sfvc_top dut (.core_clk(core_clk), .arst_n(arst_n), .pin_in(pins), .io_out(io_out), .io_oe(io_oe),
        .nonvolatile_interface_config(nv), .nv_length_update(len_pulse), .volatile_first_config_quad(q),
        .cfg_out(cfg_out), .protect_pin_enable(protect_pin_enable));
    sfvc_host host (.core_clk(core_clk), .pin_io(pins.io), .sclk(sclk), .cs_n(cs_n), .io(host_io));

    // ==========================================
    // Helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic chk(input string nm, input int exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp[7:0]) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp[7:0], got);
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // Both read commands plus the decoded outputs
    task automatic rdchk;
        logic [7:0] v;
        host.frame(m[3], {CMD_READ_CFG2, 40'h0}, 8, 0, 8, v);
        chk("read_cfg2", m, v);
        host.frame(m[3], m[0] ? {CMD_READ_ANY, CFG2_ADDR, 8'h00} : {CMD_READ_ANY, CFG2_ADDR[23:0], 16'h0},
                   m[0] ? 40 : 32, 8, 8, v);
        chk("read_any", m, v);
        chk("cfg_out", {m[6:5], m[7], m[2], m[0], m[3], m[3] | q}, {1'b0, cfg_out});
        chk("protect", !(m[3] | q), {7'h0, protect_pin_enable});
    endtask

    // Register write, optionally preceded by a write enable, 06h or 50h
    task automatic wr(input logic [7:0] c, input logic [7:0] d, input logic en);
        logic [7:0] v;
        // Both enable codes are exercised, one per write command
        if (en) host.frame(m[3], {((c == CMD_WRITE_REGS) ? CMD_WREN : CMD_WREN_VOL), 40'h0}, 8, 0, 0, v);
        if (c == CMD_WRITE_REGS) host.frame(m[3], {c, 16'h0, d, 16'h0}, 32, 0, 0, v);
        else host.frame(m[3], m[0] ? {c, CFG2_ADDR, d} : {c, CFG2_ADDR[23:0], d, 8'h00}, m[0] ? 48 : 40, 0, 0, v);
        if (en) m = (m & 32'h12) | (d & 8'hED);
    endtask

    task automatic mode(input logic [7:0] c);
        logic [7:0] v;
        host.frame(m[3], {c, 40'h0}, 8, 0, 0, v);
        if (c == CMD_ENTER_FOUR || c == CMD_EXIT_FOUR) m[3] = (c == CMD_ENTER_FOUR);
        else m[0] = (c == CMD_ENTER_LONG);
    endtask

    // ==========================================
    // Main sequence
    initial begin
        logic [7:0] v;
        int i;
        seed = xs(seed);
        nv = seed[7:0];
        repeat (10) @(negedge core_clk);
        arst_n = 1'b1;
        m = {24'h0, nv[7:2], nv[1], nv[1]};
        repeat (6) @(negedge core_clk);
        rdchk();
        // Random data through both write commands, enabled and refused
        for (i = 0; i < 8; i++) begin
            seed = xs(seed);
            wr(i[0] ? CMD_WRITE_REGS : CMD_WRITE_ANY, seed[7:0], i[1]);
            rdchk();
        end
        for (i = 0; i < 4; i++) begin
            mode(i[0] ? (i[1] ? CMD_EXIT_LONG : CMD_ENTER_LONG) : (i[1] ? CMD_EXIT_FOUR : CMD_ENTER_FOUR));
            rdchk();
        end
        // Four-wide forces quad even with quad enable clear
        wr(CMD_WRITE_ANY, 8'h61, 1'b1);
        q = 1'b0;
        mode(CMD_ENTER_FOUR);
        rdchk();
        mode(CMD_EXIT_FOUR);
        rdchk();
        q = 1'b1;
        nv[1] = ~nv[1];
        len_pulse = 1'b1;
        @(negedge core_clk);
        len_pulse = 1'b0;
        m[1:0] = {2{nv[1]}};
        repeat (4) @(negedge core_clk);
        rdchk();
        nv[7] = 1'b1;
        wr(CMD_WRITE_ANY, ~nv | 8'h80, 1'b1);
        host.pin_reset(8);
        m = {24'h0, nv[7:2], nv[1], nv[1]};
        rdchk();
        wr(CMD_WRITE_ANY, ~nv & 8'h7F, 1'b1);
        host.pin_reset(8);
        rdchk();
        host.frame(m[3], {CMD_READ_ANY, 40'h0}, m[0] ? 40 : 32, 8, 8, v);
        chk("unmapped", 0, v);
        wrap_up();
    end

    // Watchdog well beyond the expected run
    initial begin
        #1000000;
        errors++;
        wrap_up();
    end
endmodule
